// *** hw/eee_lpi_wake.sv ***
// EEE low-power-idle assert/detect, PHY quiet-refresh sequencing and
// wake-event detection for one switch port.
// Assumes MAC and MII on clk_link, config and status on clk_sys, line pins asynchronous.
`timescale 1ns/1ps
`default_nettype none
module eee_lpi_wake #(
  parameter int REFRESH_CYC = eee_pkg::REFRESH_CYC,
  parameter int QUIET_CYC = eee_pkg::QUIET_CYC
) (
  // Clocks and reset
  input wire logic clk_sys,
  input wire logic clk_link,
  input wire logic rst_b,
  // EEE control, clk_sys
  input wire logic lpi_req,
  input wire logic an_done,
  input wire logic eee_adv_local,
  input wire logic eee_adv_partner,
  // MAC transmit side, clk_link
  input wire logic [3:0] mac_txd,
  input wire logic mac_txen,
  input wire logic mac_txer,
  output logic mac_tx_hold,
  // Transmit MII toward PHY, clk_link
  output logic [3:0] mii_txd,
  output logic mii_txen,
  output logic mii_txer,
  // Receive MII from PHY, clk_link
  input wire logic [3:0] mii_rxd,
  input wire logic mii_rxdv,
  input wire logic mii_rxer,
  // MAC receive side, clk_link
  output logic [3:0] mac_rxd,
  output logic mac_rxdv,
  output logic mac_rxer,
  output logic remote_lowpower_idle_ind,
  output logic rx_full_rate,
  // Line pins, asynchronous
  input wire logic line_rx_sleep,
  input wire logic line_rx_wake,
  input wire logic energy_det,
  input wire logic link_up,
  // Line state, clk_sys and clk_link
  output logic [1:0] line_sig,
  output logic line_tx_on,
  output logic rx_pwr_save,
  // Wake configuration and status, clk_sys
  input wire logic [15:0] energy_time,
  input wire logic [2:0] wake_mask,
  input wire logic [47:0] node_mac,
  input wire logic notify_sel,
  input wire logic [2:0] wake_clr,
  output logic [2:0] wake_status,
  output logic host_irq_n,
  output logic power_event_out
);
  // ********************
  // Helpers
  // ********************
  // Byte i of an address as it appears on the wire, first byte first
  function automatic logic [7:0] mac_byte(input logic [47:0] m, input logic [2:0] i);
    mac_byte = m[8 * (5 - int'(i)) +: 8];
  endfunction

  // ********************
  // Capability gate and config crossing
  // ********************
  logic lpi_ok;
  logic [49:0] cfg_q;
  logic [51:0] ls1_q, ls2_q, ls3_q, lf_q;
  logic mp_en, lpi_l, sleep_l, wake_l;
  logic [47:0] mac_l;
  assign lpi_ok = lpi_req & an_done & eee_adv_local & eee_adv_partner;
  // Registered so only flip-flops feed the link-side synchroniser
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      cfg_q <= '0;
    end else begin
      cfg_q <= {wake_mask[eee_pkg::WK_MAGIC], node_mac, lpi_ok};
    end
  end
  // Three stages; a bit changes only once stages two and three agree
  always_ff @(posedge clk_link or negedge rst_b) begin
    if (!rst_b) begin
      ls1_q <= '0;
      ls2_q <= '0;
      ls3_q <= '0;
      lf_q <= '0;
    end else begin
      ls1_q <= {cfg_q, line_rx_sleep, line_rx_wake};
      ls2_q <= ls1_q;
      ls3_q <= ls2_q;
      lf_q <= (ls2_q & ls3_q) | (lf_q & (ls2_q | ls3_q));
    end
  end
  // The address is quasi-static; it is only sampled while frames scan
  assign {mp_en, mac_l, lpi_l, sleep_l, wake_l} = lf_q;

  // ********************
  // Transmit LPI assert
  // ********************
  logic tx_lpi_q;
  logic [7:0] tx_rec_q;
  // Recovery count starts when the request leaves
  always_ff @(posedge clk_link or negedge rst_b) begin
    if (!rst_b) begin
      tx_lpi_q <= 1'b0;
      tx_rec_q <= 8'h00;
    end else begin
      tx_lpi_q <= lpi_l;
      if (tx_lpi_q && !lpi_l) begin
        tx_rec_q <= eee_pkg::TX_RECOV_CYC;
      end else if (tx_rec_q != 8'h00) begin
        tx_rec_q <= tx_rec_q - 8'h01;
      end
    end
  end
  // The MAC client raises its request between frames only; a frame in
  // flight would be cut short by the LPI code
  always_ff @(posedge clk_link or negedge rst_b) begin
    if (!rst_b) begin
      mii_txd <= 4'h0;
      mii_txen <= 1'b0;
      mii_txer <= 1'b0;
      mac_tx_hold <= 1'b0;
    end else begin
      mac_tx_hold <= lpi_l | tx_lpi_q | (tx_rec_q != 8'h00);
      if (lpi_l) begin
        mii_txd <= eee_pkg::LPI_CODE;
        mii_txen <= 1'b0;
        mii_txer <= 1'b1;
      end else begin
        mii_txd <= mac_txd;
        mii_txen <= mac_txen;
        mii_txer <= mac_txer;
      end
    end
  end

  // ********************
  // Receive line and LPI detect
  // ********************
  logic rx_line_q, eff_lpi;
  logic [7:0] rx_rec_q;
  // Receive direction runs apart from the transmit request
  always_ff @(posedge clk_link or negedge rst_b) begin
    if (!rst_b) begin
      rx_line_q <= 1'b0;
      rx_rec_q <= 8'h00;
    end else begin
      if (sleep_l) begin
        rx_line_q <= 1'b1;
      end else if (wake_l && rx_line_q) begin
        rx_line_q <= 1'b0;
        rx_rec_q <= eee_pkg::RX_RECOV_CYC;
      end else if (rx_rec_q != 8'h00) begin
        rx_rec_q <= rx_rec_q - 8'h01;
      end
    end
  end
  assign eff_lpi = rx_line_q | (!mii_rxdv & mii_rxer & (mii_rxd == eee_pkg::LPI_CODE));
  // Indication rises only from normal idle, as a frame never ends in LPI
  always_ff @(posedge clk_link or negedge rst_b) begin
    if (!rst_b) begin
      mac_rxd <= 4'h0;
      mac_rxdv <= 1'b0;
      mac_rxer <= 1'b0;
      remote_lowpower_idle_ind <= 1'b0;
      rx_full_rate <= 1'b1;
      rx_pwr_save <= 1'b0;
    end else begin
      remote_lowpower_idle_ind <= eff_lpi & (remote_lowpower_idle_ind | !mac_rxdv);
      rx_full_rate <= !rx_line_q && (rx_rec_q == 8'h00);
      rx_pwr_save <= rx_line_q;
      if (eff_lpi) begin
        mac_rxd <= 4'h0;
        mac_rxdv <= 1'b0;
        mac_rxer <= 1'b0;
      end else begin
        mac_rxd <= mii_rxd;
        mac_rxdv <= mii_rxdv;
        mac_rxer <= mii_rxer;
      end
    end
  end

  // ********************
  // Wake-pattern scan
  // ********************
  logic hi_q, sfd_q, found_q, da_me_q, da_grp_q, mp_tog_q, byte_v, hit;
  logic [3:0] lo_q;
  logic [2:0] da_q, ff_q, bi_q;
  logic [4:0] cp_q;
  logic [7:0] rb;
  assign rb = {mac_rxd, lo_q};
  assign byte_v = mac_rxdv & hi_q & mp_en;
  assign hit = (rb == mac_byte(mac_l, bi_q));
  // Nibble pairing and address filter; unicast, multicast, broadcast pass
  always_ff @(posedge clk_link or negedge rst_b) begin
    if (!rst_b) begin
      hi_q <= 1'b0;
      lo_q <= 4'h0;
      sfd_q <= 1'b0;
      da_q <= 3'h0;
      da_me_q <= 1'b0;
      da_grp_q <= 1'b0;
      mp_tog_q <= 1'b0;
    end else if (!mac_rxdv) begin
      if (sfd_q && found_q && (da_me_q || da_grp_q)) begin
        mp_tog_q <= !mp_tog_q;
      end
      hi_q <= 1'b0;
      sfd_q <= 1'b0;
      da_q <= 3'h0;
    end else begin
      hi_q <= !hi_q;
      lo_q <= mac_rxd;
      if (byte_v && !sfd_q) begin
        sfd_q <= (rb == eee_pkg::SFD_BYTE);
        da_me_q <= 1'b1;
      end else if (byte_v && da_q != eee_pkg::SYNC_LEN) begin
        da_q <= da_q + 3'h1;
        da_me_q <= da_me_q & (rb == mac_byte(mac_l, da_q));
        if (da_q == 3'h0) begin
          da_grp_q <= rb[0];
        end
      end
    end
  end
  // Match engine; extra sync bytes keep the lock
  always_ff @(posedge clk_link or negedge rst_b) begin
    if (!rst_b) begin
      ff_q <= 3'h0;
      bi_q <= 3'h0;
      cp_q <= 5'h00;
      found_q <= 1'b0;
    end else if (!mac_rxdv) begin
      ff_q <= 3'h0;
      bi_q <= 3'h0;
      cp_q <= 5'h00;
      found_q <= 1'b0;
    end else if (byte_v && sfd_q && !found_q) begin
      if (ff_q == eee_pkg::SYNC_LEN && hit) begin
        if (bi_q == eee_pkg::MAC_LAST) begin
          bi_q <= 3'h0;
          cp_q <= cp_q + 5'h01;
          found_q <= (cp_q == eee_pkg::COPY_LAST);
        end else begin
          bi_q <= bi_q + 3'h1;
        end
      end else if (!(ff_q == eee_pkg::SYNC_LEN && cp_q == 5'h00 && bi_q == 3'h0
          && rb == eee_pkg::SYNC_BYTE)) begin
        bi_q <= 3'h0;
        cp_q <= 5'h00;
        if (rb != eee_pkg::SYNC_BYTE) begin
          ff_q <= 3'h0;
        end else if (ff_q == eee_pkg::SYNC_LEN) begin
          ff_q <= 3'h1;
        end else begin
          ff_q <= ff_q + 3'h1;
        end
      end
    end
  end

  // ********************
  // System-side crossing
  // ********************
  logic [3:0] ss1_q, ss2_q, ss3_q, sf_q;
  logic mp_old_q, link_old_q, tx_lpi_s;
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      ss1_q <= 4'h0;
      ss2_q <= 4'h0;
      ss3_q <= 4'h0;
      sf_q <= 4'h0;
      mp_old_q <= 1'b0;
      link_old_q <= 1'b0;
    end else begin
      ss1_q <= {mp_tog_q, tx_lpi_q, link_up, energy_det};
      ss2_q <= ss1_q;
      ss3_q <= ss2_q;
      sf_q <= (ss2_q & ss3_q) | (sf_q & (ss2_q | ss3_q));
      mp_old_q <= sf_q[3];
      link_old_q <= sf_q[1];
    end
  end
  assign tx_lpi_s = sf_q[2];

  // ********************
  // PHY quiet-refresh sequencer
  // ********************
  eee_pkg::eee_phy_state_type st_q, st_d;
  logic [21:0] cnt_q, cnt_d;
  logic [1:0] sig_d;
  always_comb begin
    st_d = st_q;
    cnt_d = (cnt_q != 22'h0) ? cnt_q - 22'h1 : cnt_q;
    unique case (st_q)
      eee_pkg::PH_ACTIVE: begin
        if (tx_lpi_s) begin
          st_d = eee_pkg::PH_SLEEP;
          cnt_d = eee_pkg::SLEEP_CYC - 22'h1;
        end
      end
      eee_pkg::PH_SLEEP: begin
        if (cnt_q == 22'h0) begin
          st_d = eee_pkg::PH_QUIET;
          cnt_d = 22'(QUIET_CYC - 1);
        end
      end
      eee_pkg::PH_QUIET, eee_pkg::PH_REFRESH: begin
        if (!tx_lpi_s) begin
          st_d = eee_pkg::PH_WAKE;
          cnt_d = eee_pkg::WAKE_CYC - 22'h1;
        end else if (cnt_q == 22'h0 && st_q == eee_pkg::PH_QUIET) begin
          st_d = eee_pkg::PH_REFRESH;
          cnt_d = 22'(REFRESH_CYC - 1);
        end else if (cnt_q == 22'h0) begin
          st_d = eee_pkg::PH_QUIET;
          cnt_d = 22'(QUIET_CYC - 1);
        end
      end
      eee_pkg::PH_WAKE: begin
        if (cnt_q == 22'h0) begin
          st_d = eee_pkg::PH_ACTIVE;
        end
      end
      default: begin
        st_d = eee_pkg::PH_ACTIVE;
      end
    endcase
    unique case (st_d)
      eee_pkg::PH_SLEEP: sig_d = eee_pkg::LINE_SLEEP;
      eee_pkg::PH_REFRESH: sig_d = eee_pkg::LINE_REFRESH;
      eee_pkg::PH_WAKE: sig_d = eee_pkg::LINE_WAKE;
      default: sig_d = eee_pkg::LINE_NORMAL;
    endcase
  end
  // Transmitter powers down only in quiet
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      st_q <= eee_pkg::PH_ACTIVE;
      cnt_q <= 22'h0;
      line_sig <= eee_pkg::LINE_NORMAL;
      line_tx_on <= 1'b1;
    end else begin
      st_q <= st_d;
      cnt_q <= cnt_d;
      line_sig <= sig_d;
      line_tx_on <= (st_d != eee_pkg::PH_QUIET);
    end
  end

  // ********************
  // Wake events and notify
  // ********************
  logic [15:0] en_cnt_q;
  logic [2:0] set_ev;
  logic pend;
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      en_cnt_q <= 16'h0000;
    end else if (!sf_q[0]) begin
      en_cnt_q <= 16'h0000;
    end else if (en_cnt_q != 16'hFFFF) begin
      en_cnt_q <= en_cnt_q + 16'h0001;
    end
  end
  assign set_ev = {sf_q[3] ^ mp_old_q,
    sf_q[1] & !link_old_q,
    sf_q[0] & (en_cnt_q == energy_time)};
  assign pend = |(wake_status & wake_mask);
  // Set wins over a clear in the same cycle
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      wake_status <= 3'h0;
      host_irq_n <= 1'b1;
      power_event_out <= 1'b0;
    end else begin
      wake_status <= (wake_status & ~wake_clr) | set_ev;
      host_irq_n <= !(pend && !notify_sel);
      power_event_out <= (pend && notify_sel)
        || (wake_status[eee_pkg::WK_MAGIC] && wake_mask[eee_pkg::WK_MAGIC]);
    end
  end

  // ********************
  // Assertions
  // ********************
  sequence s_tx_exit;
    $fell(tx_lpi_q) && !lpi_l;
  endsequence
  logic [21:0] run_q;
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      run_q <= 22'h0;
    end else begin
      run_q <= (st_q == eee_pkg::PH_REFRESH) ? run_q + 22'h1 : 22'h0;
    end
  end
  property p_tx_assert;
    @(posedge clk_link) disable iff (!rst_b)
    lpi_l |=> mii_txer && !mii_txen && mii_txd == eee_pkg::LPI_CODE && mac_tx_hold;
  endproperty
  a_tx_assert: assert property (p_tx_assert) else $error("LPI code not sent");
  property p_tx_recov;
    @(posedge clk_link) disable iff (!rst_b)
    s_tx_exit ##1 (!lpi_l)[*8] |-> mac_tx_hold && !mii_txer;
  endproperty
  a_tx_recov: assert property (p_tx_recov) else $error("MAC released early");
  property p_rx_pass;
    @(posedge clk_link) disable iff (!rst_b)
    !eff_lpi |=> mac_rxd == $past(mii_rxd) && mac_rxdv == $past(mii_rxdv);
  endproperty
  a_rx_pass: assert property (p_rx_pass) else $error("Receive not passed");
  property p_rx_ind;
    @(posedge clk_link) disable iff (!rst_b)
    eff_lpi && !mac_rxdv |=> remote_lowpower_idle_ind && !mac_rxdv && !mac_rxer;
  endproperty
  a_rx_ind: assert property (p_rx_ind) else $error("Remote LPI missed");
  property p_rx_end;
    @(posedge clk_link) disable iff (!rst_b)
    remote_lowpower_idle_ind && !eff_lpi |=> !remote_lowpower_idle_ind;
  endproperty
  a_rx_end: assert property (p_rx_end) else $error("Remote LPI held");
  property p_rx_sleep;
    @(posedge clk_link) disable iff (!rst_b)
    sleep_l |=> ##1 rx_pwr_save && !rx_full_rate;
  endproperty
  a_rx_sleep: assert property (p_rx_sleep) else $error("Sleep not taken");
  property p_sleep;
    @(posedge clk_sys) disable iff (!rst_b)
    st_q == eee_pkg::PH_ACTIVE && tx_lpi_s |=> (line_sig == eee_pkg::LINE_SLEEP)[*8];
  endproperty
  a_sleep: assert property (p_sleep) else $error("Sleep not sent");
  property p_wake;
    @(posedge clk_sys) disable iff (!rst_b)
    $rose(line_sig == eee_pkg::LINE_WAKE) |-> (line_sig == eee_pkg::LINE_WAKE)[*8];
  endproperty
  a_wake: assert property (p_wake) else $error("Wake too short");
  property p_refresh;
    @(posedge clk_sys) disable iff (!rst_b)
    st_q == eee_pkg::PH_REFRESH && st_d == eee_pkg::PH_QUIET |-> run_q == 22'(REFRESH_CYC - 1);
  endproperty
  a_refresh: assert property (p_refresh) else $error("Refresh length wrong");
  property p_no_lpi;
    @(posedge clk_sys) disable iff (!rst_b)
    !(eee_adv_local && eee_adv_partner) |=> !cfg_q[0];
  endproperty
  a_no_lpi: assert property (p_no_lpi) else $error("LPI without EEE");
  property p_energy;
    @(posedge clk_sys) disable iff (!rst_b)
    set_ev[eee_pkg::WK_ENERGY] |=> wake_status[eee_pkg::WK_ENERGY];
  endproperty
  a_energy: assert property (p_energy) else $error("Energy event lost");
  property p_pwr_ev;
    @(posedge clk_sys) disable iff (!rst_b)
    wake_status[eee_pkg::WK_MAGIC] && wake_mask[eee_pkg::WK_MAGIC] |=> power_event_out;
  endproperty
  a_pwr_ev: assert property (p_pwr_ev) else $error("Power event missing");
endmodule
`default_nettype wire

// *** hw/eee_pkg.sv ***
// Constants shared by the EEE low-power-idle and wake-detect port block.
// Assumes a 100 MHz system clock and a nibble-wide MII on its own clock.
`default_nettype none
package eee_pkg;
  // ********************
  // Timing
  // ********************
  localparam int CLK_MHZ = 100;
  localparam int REFRESH_US = 200;
  localparam int PERIOD_MS = 20;
  localparam int SLEEP_US = 20;
  localparam int WAKE_US = 30;
  localparam int REFRESH_CYC = REFRESH_US * CLK_MHZ;
  localparam int QUIET_CYC = (PERIOD_MS * 1000 - REFRESH_US) * CLK_MHZ;
  localparam logic [21:0] SLEEP_CYC = 22'(SLEEP_US * CLK_MHZ);
  localparam logic [21:0] WAKE_CYC = 22'(WAKE_US * CLK_MHZ);
  localparam logic [7:0] TX_RECOV_CYC = 8'h1E;
  localparam logic [7:0] RX_RECOV_CYC = 8'h1E;
  // ********************
  // Encodings
  // ********************
  localparam logic [3:0] LPI_CODE = 4'h1;
  localparam logic [7:0] SFD_BYTE = 8'hD5;
  localparam logic [7:0] SYNC_BYTE = 8'hFF;
  localparam logic [2:0] SYNC_LEN = 3'h6;
  localparam logic [2:0] MAC_LAST = 3'h5;
  localparam logic [4:0] COPY_LAST = 5'h0F;
  localparam int WK_ENERGY = 0;
  localparam int WK_LINK = 1;
  localparam int WK_MAGIC = 2;
  localparam logic [1:0] LINE_NORMAL = 2'h0;
  localparam logic [1:0] LINE_SLEEP = 2'h1;
  localparam logic [1:0] LINE_REFRESH = 2'h2;
  localparam logic [1:0] LINE_WAKE = 2'h3;
  typedef enum logic [4:0] {
    PH_ACTIVE = 5'b00001,
    PH_SLEEP = 5'b00010,
    PH_QUIET = 5'b00100,
    PH_REFRESH = 5'b01000,
    PH_WAKE = 5'b10000
  } eee_phy_state_type;
endpackage
`default_nettype wire

// *** verif/eee_phy_model.sv ***
// Behavioural PHY and far link partner for the receive direction of one port.
// Assumes the bench queues frames and line events through the tasks below.
`timescale 1ns/1ps
`default_nettype none
module eee_phy_model #(
  parameter int WAKE_LEN = 40
) (
  // Link clock
  input wire logic clk_link,
  // Receive MII toward the port
  output logic [3:0] mii_rxd,
  output logic mii_rxdv,
  output logic mii_rxer,
  // Line events from the far end
  output logic line_rx_sleep,
  output logic line_rx_wake
);
  // **********
  // Receive MII driver
  // **********
  logic [3:0] nib_q[$];
  logic [3:0] idle_pat = 4'h3;
  logic lpi_on = 1'b0;
  // Quiet lines at time zero
  initial begin
    {mii_rxd, mii_rxdv, mii_rxer} = 6'h00;
    {line_rx_sleep, line_rx_wake} = 2'h0;
  end
  // Idle nibbles keep moving so a stale value never passes for fresh data
  always @(negedge clk_link) begin
    idle_pat <= idle_pat + 4'h5;
    if (nib_q.size() > 0) begin
      mii_rxd <= nib_q.pop_front();
      {mii_rxdv, mii_rxer} <= 2'h2;
    end else if (lpi_on) begin
      mii_rxd <= eee_pkg::LPI_CODE;
      {mii_rxdv, mii_rxer} <= 2'h1;
    end else begin
      mii_rxd <= idle_pat;
      {mii_rxdv, mii_rxer} <= 2'h0;
    end
  end
  // Frames go out low nibble first, after preamble and start delimiter
  task automatic send_frame(input logic [7:0] body[$]);
    logic [7:0] b;
    for (int i = 0; i < 8 + body.size(); i++) begin
      b = (i < 7) ? 8'h55 : (i == 7) ? eee_pkg::SFD_BYTE : body[i - 8];
      nib_q.push_back(b[3:0]);
      nib_q.push_back(b[7:4]);
    end
  endtask
  // Sleep stays up until the far end wakes; wake lasts a fixed time
  task automatic sleep_line;
    @(negedge clk_link);
    line_rx_sleep = 1'b1;
  endtask
  task automatic wake_line;
    @(negedge clk_link);
    {line_rx_sleep, line_rx_wake} = 2'h1;
    repeat (WAKE_LEN) @(negedge clk_link);
    line_rx_wake = 1'b0;
  endtask
endmodule
`default_nettype wire

// *** verif/test_eee_lpi_wake.sv ***
// Self-checking bench for the port low-power-idle and wake-detect block.
// Assumes the partner model drives the receive MII and the sleep and wake line pins.
`timescale 1ns/1ps
`default_nettype none
module test_eee_lpi_wake;
  // Short quiet and refresh counts keep the run brief
  localparam int REF_N = 20;
  localparam int QUI_N = 60;
  logic clk_sys = 1'b0, clk_link = 1'b0, rst_b = 1'b0;
  logic lpi_req = 1'b0, an_done = 1'b0, eee_adv_local = 1'b0, eee_adv_partner = 1'b0;
  logic [3:0] mac_txd = 4'h0;
  logic mac_txen = 1'b0, mac_txer = 1'b0, energy_det = 1'b0, link_up = 1'b0;
  logic notify_sel = 1'b0, tx_mon = 1'b0, rx_mon = 1'b0;
  logic mac_tx_hold, mii_txen, mii_txer, mii_rxdv, mii_rxer, mac_rxdv, mac_rxer;
  logic [3:0] mii_txd, mii_rxd, mac_rxd;
  logic remote_lowpower_idle_ind, rx_full_rate, line_rx_sleep, line_rx_wake;
  logic line_tx_on, rx_pwr_save, host_irq_n, power_event_out;
  logic [1:0] line_sig;
  logic [15:0] energy_time = 16'h0040;
  logic [2:0] wake_mask = 3'h7, wake_clr = 3'h0, wake_status;
  logic [2:0] cfg [3] = '{3'h3, 3'h5, 3'h6};
  logic [47:0] node_mac = 48'h0;
  logic [31:0] seed = 32'h94DC1BD5;
  logic [7:0] fr[$];
  int failures = 0, n_tests = 0, cyc = 0, cl, cs;

  eee_lpi_wake #(.REFRESH_CYC(REF_N), .QUIET_CYC(QUI_N)) eee_lpi_wake_inst (
    .clk_sys, .clk_link, .rst_b, .lpi_req, .an_done, .eee_adv_local, .eee_adv_partner,
    .mac_txd, .mac_txen, .mac_txer, .mac_tx_hold, .mii_txd, .mii_txen, .mii_txer,
    .mii_rxd, .mii_rxdv, .mii_rxer, .mac_rxd, .mac_rxdv, .mac_rxer,
    .remote_lowpower_idle_ind, .rx_full_rate, .line_rx_sleep, .line_rx_wake,
    .energy_det, .link_up, .line_sig, .line_tx_on, .rx_pwr_save, .energy_time,
    .wake_mask, .node_mac, .notify_sel, .wake_clr, .wake_status, .host_irq_n,
    .power_event_out
  );
  eee_phy_model eee_phy_model_inst (
    .clk_link, .mii_rxd, .mii_rxdv, .mii_rxer, .line_rx_sleep, .line_rx_wake
  );

  // **********
  // Helpers
  // **********
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // Loose window for counts that cross clock domains
  function automatic logic near(input int a, input int b, input int t);
    return (a >= b - t) && (a <= b + t);
  endfunction
  function automatic logic magic_exp(input int k);
    return (k <= 2) || (k == 4);
  endfunction
  task automatic check(input logic [47:0] seen, input logic [47:0] exp);
    n_tests++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic end_sim;
    if (failures == 0 && n_tests > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic clear;
    wake_clr = 3'h7;
    @(negedge clk_sys);
    wake_clr = 3'h0;
    repeat (4) @(negedge clk_sys);
  endtask
  task automatic pulse_energy(input int n);
    energy_det = 1'b1;
    repeat (n) @(negedge clk_sys);
    energy_det = 1'b0;
    repeat (10) @(negedge clk_sys);
  endtask
  // Pattern bytes never hold FF or 80, so the filler cannot fake a match
  task automatic put_pat(input int n);
    repeat (6) fr.push_back(eee_pkg::SYNC_BYTE);
    repeat (n) for (int i = 0; i < 6; i++) fr.push_back(node_mac[47 - 8 * i -: 8]);
    fr.push_back(8'h80);
  endtask
  // Frame kinds: 0 own, 1 broadcast, 2 group, 3 short run, 4 restart, 5 foreign
  task automatic build(input int k);
    logic [47:0] da;
    fr.delete();
    seed = lfsr(seed);
    da = (k == 1) ? 48'hFFFFFFFFFFFF : (k == 2) ? {8'h01, seed, 8'h10} : node_mac;
    if (k == 5) da = node_mac ^ 48'h000000000100;
    for (int i = 0; i < 6; i++) fr.push_back(da[47 - 8 * i -: 8]);
    for (int i = 0; i < 8; i++) begin
      seed = lfsr(seed);
      fr.push_back(seed[7:0] & 8'h7F);
    end
    if (k == 4) put_pat(5);
    put_pat((k == 3) ? 15 : 16);
    repeat (4) fr.push_back(8'h80);
  endtask

  // **********
  // Clocks, stimulus and watchers
  // **********
  initial begin
    forever #5 clk_sys = ~clk_sys;
  end
  // Link clock free-running at 30 ns, offset from the system clock
  initial begin
    #3.7;
    forever #15 clk_link = ~clk_link;
  end
  always @(negedge clk_link) begin
    seed = lfsr(seed);
    mac_txd <= seed[3:0];
  end
  // Both MII directions pass through with one link cycle of delay
  always @(posedge clk_link) begin : mii_watch
    logic [47:0] r;
    logic [47:0] t;
    r = 48'({mii_rxd, mii_rxdv, mii_rxer});
    t = 48'({mac_txd, mac_txen, mac_txer});
    #1;
    if (rx_mon) check(48'({mac_rxd, mac_rxdv, mac_rxer}), r);
    if (tx_mon) check(48'({mii_txd, mii_txen, mii_txer}), t);
  end
  // Hang guard
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 40000) begin
      failures++;
      end_sim();
    end
  end

  // **********
  // Main sequence
  // **********
  initial begin
    seed = lfsr(seed);
    node_mac = 48'({seed[15:0], seed}) & 48'h7E7F7F7F7F7F;
    repeat (9) @(negedge clk_sys);
    check(48'({host_irq_n, line_tx_on, rx_full_rate, line_sig, mac_tx_hold,
      power_event_out, wake_status}), 48'h380);
    @(negedge clk_sys);
    rst_b = 1'b1;
    lpi_req = 1'b1;
    for (int k = 0; k < 3; k++) begin
      {an_done, eee_adv_local, eee_adv_partner} = cfg[k];
      repeat (40) @(negedge clk_link);
      check(48'({mac_tx_hold, mii_txer, line_sig}), 48'h0);
      @(negedge clk_sys);
    end
    {an_done, eee_adv_local, eee_adv_partner} = 3'h7;
    fork
      begin
        for (cl = 0; cl < 100 && mac_tx_hold !== 1'b1; cl++) @(negedge clk_link);
        check(48'({mac_tx_hold, mii_txen, mii_txer, mii_txd}),
          48'({3'h5, eee_pkg::LPI_CODE}));
        build(5);
        rx_mon = 1'b1;
        eee_phy_model_inst.send_frame(fr);
        for (cl = 0; cl < 3000 && eee_phy_model_inst.nib_q.size() > 0; cl++) @(negedge clk_link);
        rx_mon = 1'b0;
        check(48'(mii_txer), 48'h1);
      end
      begin
        for (cs = 0; cs < 300 && line_sig !== eee_pkg::LINE_SLEEP; cs++) @(negedge clk_sys);
        for (cs = 0; cs < 3000 && line_sig === eee_pkg::LINE_SLEEP; cs++) @(negedge clk_sys);
        check(48'({near(cs, 2000, 2), line_tx_on}), 48'h2);
        for (cs = 0; cs < 300 && line_tx_on === 1'b0; cs++) @(negedge clk_sys);
        check(48'({near(cs, QUI_N, 2), line_sig}), 48'h6);
        for (cs = 0; cs < 300 && line_sig === eee_pkg::LINE_REFRESH; cs++) @(negedge clk_sys);
        check(48'({near(cs, REF_N, 2), line_tx_on}), 48'h2);
      end
    join
    lpi_req = 1'b0;
    fork
      begin
        for (cl = 0; cl < 100 && mii_txer !== 1'b0; cl++) @(negedge clk_link);
        for (cl = 0; cl < 100 && mac_tx_hold === 1'b1; cl++) @(negedge clk_link);
        check(48'(near(cl, 31, 3)), 48'h1);
        {tx_mon, mac_txen} = 2'h3;
        repeat (20) @(negedge clk_link);
        mac_txen = 1'b0;
        repeat (2) @(negedge clk_link);
        tx_mon = 1'b0;
      end
      begin
        for (cs = 0; cs < 300 && line_sig !== eee_pkg::LINE_WAKE; cs++) @(negedge clk_sys);
        for (cs = 0; cs < 4000 && line_sig === eee_pkg::LINE_WAKE; cs++) @(negedge clk_sys);
        check(48'({near(cs, 3000, 2), line_sig, line_tx_on}), 48'h9);
      end
    join
    @(posedge clk_link);
    eee_phy_model_inst.lpi_on = 1'b1;
    for (cl = 0; cl < 6 && remote_lowpower_idle_ind !== 1'b1; cl++) @(negedge clk_link);
    repeat (10) @(negedge clk_link);
    check(48'({(cl < 4), remote_lowpower_idle_ind, mac_rxdv, mac_rxer, mii_txer}),
      48'h18);
    @(posedge clk_link);
    eee_phy_model_inst.lpi_on = 1'b0;
    repeat (3) @(negedge clk_link);
    check(48'(remote_lowpower_idle_ind), 48'h0);
    rx_mon = 1'b1;
    repeat (10) @(negedge clk_link);
    rx_mon = 1'b0;
    eee_phy_model_inst.sleep_line();
    for (cl = 0; cl < 10 && rx_pwr_save !== 1'b1; cl++) @(negedge clk_link);
    repeat (2) @(negedge clk_link);
    check(48'({rx_pwr_save, rx_full_rate, remote_lowpower_idle_ind}), 48'h5);
    fork
      eee_phy_model_inst.wake_line();
      for (cl = 0; cl < 100 && rx_full_rate !== 1'b1; cl++) @(negedge clk_link);
    join
    check(48'({near(cl, 35, 5), rx_pwr_save, remote_lowpower_idle_ind}), 48'h4);
    @(negedge clk_sys);
    {wake_mask, notify_sel} = 4'h2;
    pulse_energy(58);
    check(48'({wake_status, host_irq_n}), 48'h1);
    pulse_energy(75);
    check(48'({wake_status, host_irq_n}), 48'h2);
    clear();
    check(48'({wake_status, host_irq_n}), 48'h1);
    {wake_mask, notify_sel} = 4'h5;
    link_up = 1'b1;
    repeat (10) @(negedge clk_sys);
    check(48'({wake_status, power_event_out, host_irq_n}), 48'h0B);
    clear();
    for (int k = 0; k < 7; k++) begin
      wake_mask = (k == 6) ? 3'h3 : 3'h4;
      build((k == 6) ? 0 : k);
      eee_phy_model_inst.send_frame(fr);
      for (cl = 0; cl < 3000 && eee_phy_model_inst.nib_q.size() > 0; cl++) @(negedge clk_link);
      repeat (20) @(negedge clk_sys);
      check(48'({wake_status, power_event_out}), 48'({magic_exp(k), 3'h0} |
        {3'h0, magic_exp(k)}));
      clear();
    end
    end_sim();
  end
endmodule
`default_nettype wire
